// ===== rtl/cpu_exec_pkg.sv
/*
 * Constants and types of the exec block: APB map, flag word, opcodes.
 * Assumes one pclk domain and byte addresses on paddr[7:0].
 */
package cpu_exec_pkg;
    // APB byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_INSTR0   = 8'h08;
    localparam logic [7:0] OFS_INSTR1   = 8'h0c;
    localparam logic [7:0] OFS_SRC      = 8'h10;
    localparam logic [7:0] OFS_DST      = 8'h14;
    localparam logic [7:0] OFS_COUNT    = 8'h18;
    localparam logic [7:0] OFS_FCW      = 8'h1c;
    localparam logic [7:0] OFS_DAB      = 8'h20;
    localparam logic [7:0] OFS_PC       = 8'h24;
    localparam logic [7:0] OFS_SAVED_PC = 8'h28;
    localparam logic [7:0] OFS_CYCLES   = 8'h2c;

    // Control and status bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_SEG   = 1;
    localparam int STS_BUSY   = 0;
    localparam int STS_DONE   = 1;
    localparam int STS_INTR   = 2;
    localparam int STS_ILL    = 3;

    // Flag/control word bit positions
    localparam int FCW_H   = 2;
    localparam int FCW_D   = 3;
    localparam int FCW_V   = 4;
    localparam int FCW_S   = 5;
    localparam int FCW_Z   = 6;
    localparam int FCW_C   = 7;
    localparam int FCW_NVI = 11;
    localparam int FCW_VI  = 12;
    localparam logic [15:0] FCW_RESET = 16'h0000;

    // Opcode fields
    localparam logic [6:0]  STR_OP_HI  = 7'h5d;
    localparam logic [3:0]  STR_OP_LO  = 4'h6;
    localparam logic [3:0]  STR_W2_HI  = 4'h0;
    localparam int          STR_W_BIT  = 8;
    localparam logic [7:0]  DAB_OP_HI  = 8'hb0;
    localparam logic [3:0]  DAB_OP_LO  = 4'h0;
    localparam logic [13:0] DI_OP_HI   = 14'h1f00;
    localparam int          DI_KEEP_NVI = 0;
    localparam int          DI_KEEP_VI  = 1;

    // Word form limit and pointer steps
    localparam logic [15:0] WORD_COUNT_MAX = 16'h8000;
    localparam logic [15:0] STEP_BYTE      = 16'h0001;
    localparam logic [15:0] STEP_WORD      = 16'h0002;

    // Cycle figures
    localparam logic [31:0] CYC_CMP_BASE = 32'h0000_000b;
    localparam logic [31:0] CYC_CMP_ELEM = 32'h0000_000e;
    localparam logic [31:0] CYC_IRQ      = 32'h0000_0007;
    localparam logic [3:0]  CYC_DI       = 4'h7;
    localparam logic [3:0]  CYC_DAB      = 4'h5;

    // Decimal adjust corrections
    localparam logic [7:0] DA_NONE = 8'h00, DA_ADD_LO = 8'h06, DA_ADD_HI = 8'h60;
    localparam logic [7:0] DA_ADD_BOTH = 8'h66, DA_SUB_LO = 8'hfa;
    localparam logic [7:0] DA_SUB_HI = 8'ha0, DA_SUB_BOTH = 8'h9a;

    // Condition select codes
    localparam logic [3:0] CC_NEVER = 4'h0, CC_LT = 4'h1, CC_LE = 4'h2, CC_ULE = 4'h3;
    localparam logic [3:0] CC_OV = 4'h4, CC_MI = 4'h5, CC_EQ = 4'h6, CC_ULT = 4'h7;
    localparam logic [3:0] CC_ALWAYS = 4'h8, CC_GE = 4'h9, CC_GT = 4'ha, CC_UGT = 4'hb;
    localparam logic [3:0] CC_NOV = 4'hc, CC_PL = 4'hd, CC_NE = 4'he, CC_UGE = 4'hf;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RD_SRC = 2'b01,
        ST_RD_DST = 2'b11,
        ST_HOLD   = 2'b10
    } exec_state_t;

    typedef struct packed {
        logic        req;
        logic        word;
        logic [31:0] addr;
    } mem_cmd_t;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
    } flags_t;

    typedef struct packed {
        exec_state_t st;
        logic [15:0] flag_control_word;
        logic [31:0] source_pointer_reg;
        logic [31:0] dst_ptr;
        logic [15:0] count;
        logic [15:0] instr0;
        logic [15:0] instr1;
        logic [31:0] pc_start;
        logic [31:0] saved_pc;
        logic [7:0]  dab_data;
        logic        seg_mode;
        logic [31:0] cycles;
        logic [15:0] src_val;
        logic [3:0]  timer;
        logic        busy;
        logic        done;
        logic        interrupted;
        logic        illegal;
        logic        irq_ack;
        mem_cmd_t    mem;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;

    localparam state_t STATE_RESET = '0;
endpackage

// ===== rtl/bcd_adjust.sv
/*
 * Byte decimal adjust from carry, half-carry, nibbles and history.
 * Combinational; the caller registers result and flags.
 */
module bcd_adjust (
    input  wire logic [7:0] value,
    input  wire logic       carry_in,
    input  wire logic       half_in,
    input  wire logic       subtract,
    output logic      [7:0] result,
    output logic            carry_out
);
    logic       lo_gt9;
    logic       hi_gt9;
    logic       hi_ge9;
    logic       fix_lo;
    logic       fix_hi;
    logic [7:0] corr;

    always_comb begin
        lo_gt9 = value[3:0] > 4'h9;
        hi_gt9 = value[7:4] > 4'h9;
        hi_ge9 = value[7:4] >= 4'h9;
        if (subtract) begin
            // Carry and half-carry alone pick the row after a subtraction
            corr = carry_in ? (half_in ? cpu_exec_pkg::DA_SUB_BOTH : cpu_exec_pkg::DA_SUB_HI)
                            : (half_in ? cpu_exec_pkg::DA_SUB_LO : cpu_exec_pkg::DA_NONE);
            carry_out = carry_in;
            fix_lo = half_in;
            fix_hi = carry_in;
        end else begin
            fix_lo = half_in | lo_gt9;
            fix_hi = carry_in | hi_gt9 | (hi_ge9 & lo_gt9);
            corr = fix_hi ? (fix_lo ? cpu_exec_pkg::DA_ADD_BOTH : cpu_exec_pkg::DA_ADD_HI)
                          : (fix_lo ? cpu_exec_pkg::DA_ADD_LO : cpu_exec_pkg::DA_NONE);
            carry_out = fix_hi;
        end
        result = value + corr;
    end
endmodule

// ===== rtl/string_compare_bcd_intmask_exec.sv
/*
 * String compare with post-increment, byte decimal adjust and
 * interrupt mask clear on the flag/control word.
 * Assumes APB on pclk, a same-clock memory port with a one-cycle
 * mem_ack per held request, and a same-clock irq_req.
 */
// Chosen here: register access over APB and the address map.
// Functional notes
// - Compare is dst minus src, nothing written; Z set when condition holds.
// - Both pointers step by one for bytes, two for words.
// - Count drops by one per step; stop on condition or zero count.
// - Up to 65536 byte or 32768 word elements.
// - Interrupt taken between steps; start address saved for resumption.
// - Each accepted interrupt adds seven cycles.
// - Carry is the borrow of the last compare.
// - S from last result, V from zero count; D and H kept.
// - Two-word compare encoding decoded; time 11 plus 14 per element.
// - Time counts elements actually compared.
// - Pointers one word nonsegmented, a register pair segmented.
// - Addition adjust adds 00, 06, 60 or 66; carry on 60, 66.
// - Subtraction adjust adds 00, FA, A0 or 9A; carry on A0, 9A.
// - Adjust sets Z on zero, S from bit 7; V, D, H kept.
// - Mask clear drops each enable whose instruction bit is zero.
// - Mask clear keeps other bits and flags; seven cycles.
module string_compare_bcd_intmask_exec (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output cpu_exec_pkg::mem_cmd_t      mem_cmd,
    input  wire logic [15:0]            mem_rdata,
    input  wire logic                   mem_ack,
    input  wire logic                   irq_req,
    output logic                        irq_ack
);
    cpu_exec_pkg::state_t   cur_reg;
    cpu_exec_pkg::state_t   cur_next;
    logic [7:0]             dab_result;
    logic                   dab_carry;

    // Condition select evaluated against the compare flags
    function automatic logic cond_true(input logic [3:0] cc, input cpu_exec_pkg::flags_t f);
        logic r;
        r = 1'b0;
        unique case (cc)
            cpu_exec_pkg::CC_NEVER:  r = 1'b0;
            cpu_exec_pkg::CC_LT:     r = f.s ^ f.v;
            cpu_exec_pkg::CC_LE:     r = f.z | (f.s ^ f.v);
            cpu_exec_pkg::CC_ULE:    r = f.c | f.z;
            cpu_exec_pkg::CC_OV:     r = f.v;
            cpu_exec_pkg::CC_MI:     r = f.s;
            cpu_exec_pkg::CC_EQ:     r = f.z;
            cpu_exec_pkg::CC_ULT:    r = f.c;
            cpu_exec_pkg::CC_ALWAYS: r = 1'b1;
            cpu_exec_pkg::CC_GE:     r = ~(f.s ^ f.v);
            cpu_exec_pkg::CC_GT:     r = ~(f.z | (f.s ^ f.v));
            cpu_exec_pkg::CC_UGT:    r = ~(f.c | f.z);
            cpu_exec_pkg::CC_NOV:    r = ~f.v;
            cpu_exec_pkg::CC_PL:     r = ~f.s;
            cpu_exec_pkg::CC_NE:     r = ~f.z;
            cpu_exec_pkg::CC_UGE:    r = ~f.c;
        endcase
        return r;
    endfunction

    // Flags of dst - src; c is the borrow, the inverse of carry out
    function automatic cpu_exec_pkg::flags_t cmp_flags(input logic word,
                                                       input logic [15:0] d,
                                                       input logic [15:0] s);
        cpu_exec_pkg::flags_t f;
        logic [16:0]          w;
        logic [8:0]           b;
        w = {1'b0, d} + {1'b0, ~s} + 17'h00001;
        b = {1'b0, d[7:0]} + {1'b0, ~s[7:0]} + 9'h001;
        if (word) begin
            f.c = ~w[16];
            f.z = (w[15:0] == 16'h0000);
            f.s = w[15];
            f.v = (d[15] ^ s[15]) & (d[15] ^ w[15]);
        end else begin
            f.c = ~b[8];
            f.z = (b[7:0] == 8'h00);
            f.s = b[7];
            f.v = (d[7] ^ s[7]) & (d[7] ^ b[7]);
        end
        return f;
    endfunction

    // Nonsegmented pointers use only the low word as the address
    function automatic logic [31:0] addr_of(input logic [31:0] ptr, input logic seg);
        return seg ? ptr : {16'h0000, ptr[15:0]};
    endfunction

    // Offset wraps inside its segment; the high word is left alone
    function automatic logic [31:0] ptr_step(input logic [31:0] ptr, input logic word);
        logic [15:0] off;
        off = ptr[15:0] + (word ? cpu_exec_pkg::STEP_WORD : cpu_exec_pkg::STEP_BYTE);
        return {ptr[31:16], off};
    endfunction

    bcd_adjust u_bcd (
        .value     (cur_reg.dab_data),
        .carry_in  (cur_reg.flag_control_word[cpu_exec_pkg::FCW_C]),
        .half_in   (cur_reg.flag_control_word[cpu_exec_pkg::FCW_H]),
        .subtract  (cur_reg.flag_control_word[cpu_exec_pkg::FCW_D]),
        .result    (dab_result),
        .carry_out (dab_carry)
    );

    always_comb begin
        logic                 access;
        logic                 wr_now;
        logic                 start;
        logic                 is_str;
        logic                 is_dab;
        logic                 is_di;
        logic                 word;
        logic                 hit;
        logic                 last;
        logic [15:0]          cnt_dec;
        logic [31:0]          rd;
        cpu_exec_pkg::flags_t f;
        access   = psel & penable;
        wr_now   = 1'b0;
        start    = 1'b0;
        hit      = 1'b0;
        last     = 1'b0;
        rd       = 32'h0000_0000;
        f        = '0;
        cnt_dec  = cur_reg.count - 16'h0001;
        word     = cur_reg.instr0[cpu_exec_pkg::STR_W_BIT];
        is_str   = (cur_reg.instr0[15:9] == cpu_exec_pkg::STR_OP_HI)
                 & (cur_reg.instr0[3:0] == cpu_exec_pkg::STR_OP_LO)
                 & (cur_reg.instr1[15:12] == cpu_exec_pkg::STR_W2_HI);
        is_dab   = (cur_reg.instr0[15:8] == cpu_exec_pkg::DAB_OP_HI)
                 & (cur_reg.instr0[3:0] == cpu_exec_pkg::DAB_OP_LO);
        is_di    = (cur_reg.instr0[15:2] == cpu_exec_pkg::DI_OP_HI);
        cur_next = cur_reg;
        cur_next.irq_ack = 1'b0;
        cur_next.pready  = 1'b0;
        cur_next.pslverr = 1'b0;

        // pready one cycle into access
        unique case (paddr[7:0])
            cpu_exec_pkg::OFS_CTRL:     rd = {30'h0, cur_reg.seg_mode, 1'b0};
            cpu_exec_pkg::OFS_STATUS:   rd = {28'h0, cur_reg.illegal, cur_reg.interrupted,
                                              cur_reg.done, cur_reg.busy};
            cpu_exec_pkg::OFS_INSTR0:   rd = {16'h0, cur_reg.instr0};
            cpu_exec_pkg::OFS_INSTR1:   rd = {16'h0, cur_reg.instr1};
            cpu_exec_pkg::OFS_SRC:      rd = cur_reg.source_pointer_reg;
            cpu_exec_pkg::OFS_DST:      rd = cur_reg.dst_ptr;
            cpu_exec_pkg::OFS_COUNT:    rd = {16'h0, cur_reg.count};
            cpu_exec_pkg::OFS_FCW:      rd = {16'h0, cur_reg.flag_control_word};
            cpu_exec_pkg::OFS_DAB:      rd = {24'h0, cur_reg.dab_data};
            cpu_exec_pkg::OFS_PC:       rd = cur_reg.pc_start;
            cpu_exec_pkg::OFS_SAVED_PC: rd = cur_reg.saved_pc;
            cpu_exec_pkg::OFS_CYCLES:   rd = cur_reg.cycles;
            default:                    rd = 32'h0000_0000;
        endcase
        if (access && !cur_reg.pready) begin
            cur_next.pready  = 1'b1;
            cur_next.pslverr = (paddr[31:8] != 24'h0) || (paddr[7:0] > cpu_exec_pkg::OFS_CYCLES)
                             || (paddr[1:0] != 2'b00);
            cur_next.prdata  = cur_next.pslverr ? 32'h0000_0000 : rd;
        end
        // Write lands on the edge that samples pready high
        wr_now = access & pwrite & cur_reg.pready & ~cur_reg.pslverr;

        // Operands frozen while an instruction runs
        if (wr_now && !cur_reg.busy) begin
            unique case (paddr[7:0])
                cpu_exec_pkg::OFS_CTRL: begin
                    cur_next.seg_mode = pwdata[cpu_exec_pkg::CTRL_SEG];
                    start = pwdata[cpu_exec_pkg::CTRL_START];
                end
                cpu_exec_pkg::OFS_INSTR0: cur_next.instr0             = pwdata[15:0];
                cpu_exec_pkg::OFS_INSTR1: cur_next.instr1             = pwdata[15:0];
                cpu_exec_pkg::OFS_SRC:    cur_next.source_pointer_reg = pwdata;
                cpu_exec_pkg::OFS_DST:    cur_next.dst_ptr            = pwdata;
                cpu_exec_pkg::OFS_COUNT:  cur_next.count              = pwdata[15:0];
                cpu_exec_pkg::OFS_FCW:    cur_next.flag_control_word  = pwdata[15:0];
                cpu_exec_pkg::OFS_DAB:    cur_next.dab_data           = pwdata[7:0];
                cpu_exec_pkg::OFS_PC:     cur_next.pc_start           = pwdata;
                default: begin
                end
            endcase
        end

        unique case (cur_reg.st)
            cpu_exec_pkg::ST_IDLE: begin
                if (start) begin
                    cur_next.busy        = 1'b1;
                    cur_next.done        = 1'b0;
                    cur_next.interrupted = 1'b0;
                    cur_next.illegal     = 1'b0;
                    if (is_str) begin
                        // Count 0 is 65536: too long for words
                        if (word && ((cur_reg.count == 16'h0000)
                                     || (cur_reg.count > cpu_exec_pkg::WORD_COUNT_MAX))) begin
                            cur_next.busy    = 1'b0;
                            cur_next.done    = 1'b1;
                            cur_next.illegal = 1'b1;
                        end else begin
                            cur_next.cycles   = cpu_exec_pkg::CYC_CMP_BASE;
                            cur_next.mem.req  = 1'b1;
                            cur_next.mem.word = word;
                            cur_next.mem.addr = addr_of(cur_reg.source_pointer_reg,
                                                        cur_reg.seg_mode);
                            cur_next.st       = cpu_exec_pkg::ST_RD_SRC;
                        end
                    end else if (is_dab) begin
                        cur_next.dab_data = dab_result;
                        cur_next.flag_control_word[cpu_exec_pkg::FCW_C] = dab_carry;
                        cur_next.flag_control_word[cpu_exec_pkg::FCW_Z] =
                            (dab_result == 8'h00);
                        cur_next.flag_control_word[cpu_exec_pkg::FCW_S] = dab_result[7];
                        cur_next.cycles = {28'h0, cpu_exec_pkg::CYC_DAB};
                        cur_next.timer  = cpu_exec_pkg::CYC_DAB;
                        cur_next.st     = cpu_exec_pkg::ST_HOLD;
                    end else if (is_di) begin
                        if (!cur_reg.instr0[cpu_exec_pkg::DI_KEEP_NVI]) begin
                            cur_next.flag_control_word[cpu_exec_pkg::FCW_NVI] = 1'b0;
                        end
                        if (!cur_reg.instr0[cpu_exec_pkg::DI_KEEP_VI]) begin
                            cur_next.flag_control_word[cpu_exec_pkg::FCW_VI] = 1'b0;
                        end
                        cur_next.cycles = {28'h0, cpu_exec_pkg::CYC_DI};
                        cur_next.timer  = cpu_exec_pkg::CYC_DI;
                        cur_next.st     = cpu_exec_pkg::ST_HOLD;
                    end else begin
                        cur_next.busy    = 1'b0;
                        cur_next.done    = 1'b1;
                        cur_next.illegal = 1'b1;
                    end
                end
            end
            cpu_exec_pkg::ST_RD_SRC: begin
                if (mem_ack) begin
                    cur_next.src_val  = word ? mem_rdata : {8'h00, mem_rdata[7:0]};
                    cur_next.mem.addr = addr_of(cur_reg.dst_ptr, cur_reg.seg_mode);
                    cur_next.st       = cpu_exec_pkg::ST_RD_DST;
                end
            end
            cpu_exec_pkg::ST_RD_DST: begin
                if (mem_ack) begin
                    // Flags, pointers and count change; memory is never written
                    f    = cmp_flags(word, mem_rdata, cur_reg.src_val);
                    hit  = cond_true(cur_reg.instr1[3:0], f);
                    last = hit | (cnt_dec == 16'h0000);
                    cur_next.flag_control_word[cpu_exec_pkg::FCW_Z] = hit;
                    cur_next.flag_control_word[cpu_exec_pkg::FCW_C] = f.c;
                    cur_next.flag_control_word[cpu_exec_pkg::FCW_S] = f.s;
                    cur_next.flag_control_word[cpu_exec_pkg::FCW_V] =
                        (cnt_dec == 16'h0000);
                    cur_next.source_pointer_reg = ptr_step(cur_reg.source_pointer_reg, word);
                    cur_next.dst_ptr = ptr_step(cur_reg.dst_ptr, word);
                    cur_next.count   = cnt_dec;
                    cur_next.cycles  = cur_reg.cycles + cpu_exec_pkg::CYC_CMP_ELEM;
                    if (last) begin
                        cur_next.mem.req = 1'b0;
                        cur_next.busy    = 1'b0;
                        cur_next.done    = 1'b1;
                        cur_next.st      = cpu_exec_pkg::ST_IDLE;
                    end else if (irq_req && (cur_reg.flag_control_word[cpu_exec_pkg::FCW_VI]
                                 || cur_reg.flag_control_word[cpu_exec_pkg::FCW_NVI])) begin
                        // Registers already advanced, so a restart resumes here
                        cur_next.saved_pc    = cur_reg.pc_start;
                        cur_next.irq_ack     = 1'b1;
                        cur_next.interrupted = 1'b1;
                        cur_next.cycles      = cur_reg.cycles + cpu_exec_pkg::CYC_CMP_ELEM
                                             + cpu_exec_pkg::CYC_IRQ;
                        cur_next.mem.req     = 1'b0;
                        cur_next.busy        = 1'b0;
                        cur_next.st          = cpu_exec_pkg::ST_IDLE;
                    end else begin
                        cur_next.mem.addr = addr_of(ptr_step(cur_reg.source_pointer_reg, word),
                                                    cur_reg.seg_mode);
                        cur_next.st       = cpu_exec_pkg::ST_RD_SRC;
                    end
                end
            end
            cpu_exec_pkg::ST_HOLD: begin
                // Pads short operations to length
                if (cur_reg.timer == 4'h1) begin
                    cur_next.busy = 1'b0;
                    cur_next.done = 1'b1;
                    cur_next.st   = cpu_exec_pkg::ST_IDLE;
                end else begin
                    cur_next.timer = cur_reg.timer - 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= cpu_exec_pkg::STATE_RESET;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign prdata  = cur_reg.prdata;
    assign pready  = cur_reg.pready;
    assign pslverr = cur_reg.pslverr;
    assign mem_cmd = cur_reg.mem;
    assign irq_ack = cur_reg.irq_ack;
endmodule

// ===== tb/exec_chk.sv
/* Checker: APB timing, memory hold, interrupt pulse.
   Assumes one pclk domain, async active-low presetn. */
module exec_chk (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input cpu_exec_pkg::mem_cmd_t      mem_cmd,
    input wire logic [15:0]            mem_rdata,
    input wire logic                   mem_ack,
    input wire logic                   irq_req,
    input wire logic                   irq_ack
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_one; pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
    property p_rdy_acc; pready |-> psel && penable && $past(penable); endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside second access cycle");
    property p_rdy_wait; psel && penable && !$past(penable) |=> pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready not after one wait");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready or with data");
    property p_hold; mem_cmd.req && !mem_ack |=> mem_cmd.req && $stable(mem_cmd.addr); endproperty
    a_hold: assert property (p_hold) else $error("memory request dropped before ack");
    property p_ack_one; irq_ack |=> !irq_ack; endproperty
    a_ack_one: assert property (p_ack_one) else $error("irq_ack not a pulse");
    property p_ack_cause; irq_ack |-> $past(irq_req) || $past(irq_req, 2); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("irq_ack without request");
    property p_ack_drop; irq_ack |-> ##[0:1] !mem_cmd.req; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("memory busy after irq_ack");
endmodule
bind string_compare_bcd_intmask_exec exec_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_cmd, .mem_rdata, .mem_ack, .irq_req,
    .irq_ack);

// ===== tb/exec_mem_model.sv
/* System memory model: acks each held read after lat idle cycles.
   Assumes the bench fills mem and sets lat by hierarchical access. */
module exec_mem_model (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input cpu_exec_pkg::mem_cmd_t      mem_cmd,
    output logic      [15:0]           mem_rdata,
    output logic                       mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:1023];
    int          wt;
    int          lat = 0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {wt, mem_ack, mem_rdata} <= '0;
        end else if (mem_cmd.req && !mem_ack && wt >= lat) begin
            mem_ack <= 1'b1;
            wt <= 0;
            mem_rdata <= mem[mem_cmd.addr[9:0]];
        end else begin
            // Data not held once the ack is gone
            mem_ack <= 1'b0;
            wt <= mem_cmd.req ? wt + 1 : 0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ===== tb/testbench.sv
/* Bench: mask clear, decimal adjust, string compare with interrupt.
   Assumes the exec block APB map. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_req = 0;
    logic mem_ack, pready, pslverr, irq_ack, e;
    logic [31:0] paddr = 0, pwdata = 0, prdata, q;
    logic [15:0] mem_rdata;
    logic [23:0] t [8] = '{24'h3c4200, 24'ha50501, 24'h9a0001, 24'h127861,
                           24'h0f0930, 24'h852551, 24'h6f0971, 24'h454510};
    cpu_exec_pkg::mem_cmd_t mem_cmd;
    int err_total = 0, checked = 0, cyc = 0;
    always #5 pclk = ~pclk;
    string_compare_bcd_intmask_exec u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mem_cmd, .mem_rdata, .mem_ack, .irq_req, .irq_ack);
    exec_mem_model u_mem (.pclk, .presetn, .mem_cmd, .mem_rdata, .mem_ack);
    task chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, 24'h0, a, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b0;
        @(posedge pclk);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(q, x);
    endtask
    task run(input logic [15:0] i0);
        apb(1, 8'h08, {16'h0, i0});
        apb(1, 8'h00, 32'h1);
        do apb(0, 8'h04, 0); while (q[0] !== 1'b0);
    endtask
    task finish_test;
        $display("%0d checks, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            u_mem.mem[10'h100 + i] = 16'(i + 1);
            u_mem.mem[10'h200 + i] = (i == 2) ? 16'h3 : 16'h9;
        end
        {u_mem.mem[10'h300], u_mem.mem[10'h302]} = 32'h1000_2000;
        {u_mem.mem[10'h400], u_mem.mem[10'h402]} = 32'h1000_1fff;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int b = 0; b < 4; b++) begin
            apb(1, 8'h1c, 32'h18fc);
            run({cpu_exec_pkg::DI_OP_HI, 2'(b)});
            rc(8'h1c, 32'h00fc | (b[0] ? 32'h800 : 32'h0) | (b[1] ? 32'h1000 : 32'h0));
        end
        $display("mask clear test done");
        foreach (t[i]) begin
            apb(1, 8'h20, {24'h0, t[i][23:16]});
            apb(1, 8'h1c, {24'h0, t[i][6], 3'b001, t[i][4], t[i][5], 2'b00});
            run(16'hb000);
            rc(8'h20, {24'h0, t[i][15:8]});
            rc(8'h1c, {24'h0, t[i][0], t[i][15:8] == 8'h0, t[i][15], 1'b1, t[i][4], t[i][5], 2'b0});
        end
        $display("decimal adjust test done");
        // Distinct register fields
        apb(1, 8'h10, 32'h100);
        apb(1, 8'h14, 32'h200);
        apb(1, 8'h18, 32'h4);
        apb(1, 8'h1c, 32'h0);
        apb(1, 8'h0c, 32'h0126);
        run(16'hba36);
        rc(8'h10, 32'h103);
        rc(8'h14, 32'h203);
        rc(8'h18, 32'h1);
        rc(8'h1c, 32'h40);
        rc(8'h2c, 32'h35);
        $display("byte compare test done");
        {u_mem.lat, irq_req} <= {32'd3, 1'b1};
        apb(1, 8'h10, 32'h300);
        apb(1, 8'h14, 32'h400);
        apb(1, 8'h18, 32'h2);
        apb(1, 8'h1c, 32'h1000);
        apb(1, 8'h24, 32'h1234);
        apb(1, 8'h0c, 32'h012e);
        run(16'hbb36);
        chk(q & 32'h4, 32'h4);
        rc(8'h28, 32'h1234);
        rc(8'h10, 32'h302);
        rc(8'h2c, 32'h20);
        irq_req <= 0;
        run(16'hbb36);
        rc(8'h14, 32'h404);
        rc(8'h18, 32'h0);
        rc(8'h1c, 32'h10f0);
        rc(8'h2c, 32'h19);
        apb(1, 8'h18, 32'h8001);
        run(16'hbb36);
        chk(q & 32'h8, 32'h8);
        apb(0, 8'h30, 0);
        chk({q[30:0], e}, 32'h1);
        $display("word compare test done");
        finish_test;
    end
endmodule
